//--- rtl/hdu_core.sv
/*
 * hdu_core: half-duplex asynchronous transmitter and receiver with a data
 * and a control register on a classic wishbone slave.
 * assumes clk at 10 MHz, an asynchronous serial input from a pin, and a
 * port mux outside that takes tx_output_select to choose the engine output.
 */
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps

module hdu_core
    import hdu_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // static option: 1 selects the 11-bit frame
    input  wire logic        frame11_strap,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // serial link
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             tx_output_select,
    // interrupt requests to the core
    output logic             rx_irq,
    output logic             tx_irq
);

    function automatic logic [12:0] baud_divisor(input logic [2:0] code);
        case (code)
            3'h0:    baud_divisor = DIV_0;
            3'h1:    baud_divisor = DIV_1;
            3'h2:    baud_divisor = DIV_2;
            3'h3:    baud_divisor = DIV_3;
            3'h4:    baud_divisor = DIV_4;
            3'h5:    baud_divisor = DIV_5;
            3'h6:    baud_divisor = DIV_6;
            default: baud_divisor = DIV_7;
        endcase
    endfunction

    function automatic logic majority3(input logic a, input logic b, input logic c);
        majority3 = (a & b) | (a & c) | (b & c);
    endfunction

    hdu_wb_req_s req;
    hdu_txpin_s  pin_nxt;
    logic        strap_done_r;
    logic        frame11_r;
    logic [7:0]  rx_buffer_r;
    logic        rx_ready_flag_r;
    logic        tx_empty_flag_r;
    logic        rx_irq_enable_r;
    logic        tx_irq_enable_r;
    logic [2:0]  baud_select_r;
    logic        parity_or_ninth_bit_r;
    logic [12:0] div_cnt_r;
    logic        tick;
    logic        sync1_r;
    logic        sync2_r;
    logic        rx_prev_r;
    hdu_tx_e     tx_state_r;
    logic [2:0]  tx_phase_r;
    logic [3:0]  tx_bit_r;
    logic [8:0]  tx_shift_r;
    logic        tx_level_r;
    hdu_rx_e     rx_state_r;
    logic [2:0]  rx_phase_r;
    logic [3:0]  rx_bit_r;
    logic [8:0]  rx_shift_r;
    logic [2:0]  samp_r;
    logic        access;
    logic        hit_data;
    logic        hit_ctl;
    logic        hit_stat;
    logic        wr_data;
    logic        wr_ctl;
    logic        tx_done;
    logic        rx_done;
    logic [3:0]  nbits;
    logic        bit_val;
    logic [7:0]  tx_byte;

    assign req      = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
    assign access   = req.cyc & req.stb & ~wb_ack_o & ~wb_err_o;
    assign hit_data = req.adr == ADDR_DATA;
    assign hit_ctl  = req.adr == ADDR_CONTROL;
    assign hit_stat = req.adr == ADDR_STATUS;
    assign wr_data  = access & req.we & hit_data & req.sel[0];
    assign wr_ctl   = access & req.we & hit_ctl & req.sel[0];
    assign nbits    = frame11_r ? 4'd9 : 4'd8;
    assign bit_val  = majority3(samp_r[0], samp_r[1], samp_r[2]);
    assign tx_done  = tick && tx_state_r == HDU_TX_STOP && tx_phase_r == 3'(OVERSAMPLE - 1);
    assign rx_done  = tick && rx_state_r == HDU_RX_STOP && rx_phase_r == 3'(OVERSAMPLE - 1);
    // with auto parity the top bit is replaced by even parity of the low seven
    assign tx_byte  = (!frame11_r && parity_or_ninth_bit_r)
                    ? {^req.dat[6:0], req.dat[6:0]} : req.dat[7:0];

    // frame option caught once after reset release, then frozen
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_done_r <= 1'b0;
            frame11_r    <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            strap_done_r <= 1'b1;
            frame11_r    <= frame11_strap;
        end
    end

    // bus answer: registered ack one cycle after the request, unmapped addresses get err
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= access & (hit_data | hit_ctl | hit_stat);
            wb_err_o <= access & ~(hit_data | hit_ctl | hit_stat);
            wb_dat_o <= 32'h0000_0000;
            if (access && !req.we)
            begin
                if (hit_data)
                    wb_dat_o <= {24'h000000, rx_buffer_r};
                else if (hit_ctl)
                    wb_dat_o <= {24'h000000, rx_ready_flag_r, tx_empty_flag_r, rx_irq_enable_r,
                                 tx_irq_enable_r, baud_select_r, parity_or_ninth_bit_r};
                else if (hit_stat)
                    wb_dat_o <= {28'h0000000, frame11_r, tx_state_r != HDU_TX_IDLE,
                                 rx_state_r != HDU_RX_IDLE, 1'b0};
            end
        end
    end

    // control fields written by software
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_irq_enable_r <= CONTROL_RESET[CTL_RX_IEN];
            tx_irq_enable_r <= CONTROL_RESET[CTL_TX_IEN];
            baud_select_r   <= CONTROL_RESET[CTL_BAUD_HI:CTL_BAUD_LO];
        end
        else if (wr_ctl)
        begin
            rx_irq_enable_r <= req.dat[CTL_RX_IEN];
            tx_irq_enable_r <= req.dat[CTL_TX_IEN];
            baud_select_r   <= req.dat[CTL_BAUD_HI:CTL_BAUD_LO];
        end
    end

    // ninth bit / parity bit: reception overrides a same-cycle write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            parity_or_ninth_bit_r <= CONTROL_RESET[CTL_PAR_NINTH];
        else if (rx_done)
            parity_or_ninth_bit_r <= frame11_r ? rx_shift_r[8] : ^rx_shift_r[7:0];
        else if (wr_ctl)
            parity_or_ninth_bit_r <= req.dat[CTL_PAR_NINTH];
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_ready_flag_r <= CONTROL_RESET[CTL_RX_READY];
            tx_empty_flag_r <= CONTROL_RESET[CTL_TX_EMPTY];
        end
        else
        begin
            if (rx_done)
                rx_ready_flag_r <= 1'b1;
            else if (wr_ctl)
                rx_ready_flag_r <= req.dat[CTL_RX_READY];
            if (tx_done)
                tx_empty_flag_r <= 1'b1;
            else if (wr_data)
                tx_empty_flag_r <= 1'b0;
            else if (wr_ctl)
                tx_empty_flag_r <= req.dat[CTL_TX_EMPTY];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
        end
        else
        begin
            rx_irq <= rx_ready_flag_r & rx_irq_enable_r;
            tx_irq <= tx_empty_flag_r & tx_irq_enable_r;
        end
    end

    // divider to eight ticks per bit; divisor read live, so changes act at once
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt_r <= 13'h0000;
            tick      <= 1'b0;
        end
        else if (div_cnt_r >= baud_divisor(baud_select_r) - 13'd1)
        begin
            div_cnt_r <= 13'h0000;
            tick      <= 1'b1;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 13'd1;
            tick      <= 1'b0;
        end
    end

    // input synchroniser; only sync2 feeds logic
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_r   <= 1'b1;
            sync2_r   <= 1'b1;
            rx_prev_r <= 1'b1;
        end
        else
        begin
            sync1_r   <= serial_in_pin;
            sync2_r   <= sync1_r;
            rx_prev_r <= sync2_r;
        end
    end

    // transmitter
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_state_r <= HDU_TX_IDLE;
            tx_phase_r <= 3'h0;
            tx_bit_r   <= 4'h0;
            tx_shift_r <= 9'h000;
            tx_level_r <= 1'b1;
        end
        else if (wr_data)
        begin
            tx_state_r <= HDU_TX_START;
            tx_phase_r <= 3'h0;
            tx_bit_r   <= 4'h0;
            tx_shift_r <= {parity_or_ninth_bit_r, tx_byte};
            tx_level_r <= 1'b0;
        end
        else if (tick)
        begin
            tx_phase_r <= tx_phase_r + 3'h1;
            if (tx_phase_r == 3'(OVERSAMPLE - 1))
            begin
                case (tx_state_r)
                    HDU_TX_START, HDU_TX_BITS:
                    begin
                        if (tx_state_r == HDU_TX_BITS && tx_bit_r == nbits)
                        begin
                            tx_state_r <= HDU_TX_STOP;
                            tx_level_r <= 1'b1;
                        end
                        else
                        begin
                            tx_state_r <= HDU_TX_BITS;
                            tx_level_r <= tx_shift_r[0];
                            tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                            tx_bit_r   <= tx_bit_r + 4'h1;
                        end
                    end
                    HDU_TX_STOP:
                        tx_state_r <= HDU_TX_IDLE;
                    default:
                        tx_state_r <= HDU_TX_IDLE;
                endcase
            end
        end
    end

    // pin outputs registered; select rises with the start level, never ahead of it,
    // and drops after the stop bit
    assign pin_nxt = '{out_level: tx_level_r,
                       out_select: tx_state_r != HDU_TX_IDLE && !tx_done};
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            serial_out_pin   <= 1'b1;
            tx_output_select <= 1'b0;
        end
        else
        begin
            serial_out_pin   <= pin_nxt.out_level;
            tx_output_select <= pin_nxt.out_select;
        end
    end

    // receiver
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_state_r <= HDU_RX_IDLE;
            rx_phase_r <= 3'h0;
            rx_bit_r   <= 4'h0;
            rx_shift_r <= 9'h000;
            samp_r     <= 3'h7;
        end
        else if (wr_data || tx_state_r != HDU_TX_IDLE)
            rx_state_r <= HDU_RX_IDLE;
        else
        begin
            case (rx_state_r)
                HDU_RX_IDLE:
                    if (rx_prev_r && !sync2_r)
                    begin
                        rx_state_r <= HDU_RX_START;
                        rx_phase_r <= 3'h0;
                        rx_bit_r   <= 4'h0;
                    end
                default:
                    if (tick)
                    begin
                        rx_phase_r <= rx_phase_r + 3'h1;
                        if (rx_phase_r == SAMPLE_A)
                            samp_r[0] <= sync2_r;
                        if (rx_phase_r == SAMPLE_B)
                            samp_r[1] <= sync2_r;
                        if (rx_phase_r == SAMPLE_C)
                            samp_r[2] <= sync2_r;
                        if (rx_phase_r == 3'(OVERSAMPLE - 1))
                        begin
                            if (rx_state_r == HDU_RX_START)
                                rx_state_r <= HDU_RX_BITS;
                            else if (rx_state_r == HDU_RX_BITS)
                            begin
                                rx_shift_r <= frame11_r ? {bit_val, rx_shift_r[8:1]}
                                                        : {1'b0, bit_val, rx_shift_r[7:1]};
                                rx_bit_r   <= rx_bit_r + 4'h1;
                                if (rx_bit_r == nbits - 4'h1)
                                    rx_state_r <= HDU_RX_STOP;
                            end
                            else
                                rx_state_r <= HDU_RX_IDLE;
                        end
                    end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rx_buffer_r <= DATA_RESET;
        else if (rx_done && tx_state_r == HDU_TX_IDLE && !wr_data)
            rx_buffer_r <= rx_shift_r[7:0];
    end

endmodule

//--- common/hdu_pkg.sv
/*
 * hdu_pkg: register offsets, field positions, reset values, baud divisors
 * and shared types for the half-duplex serial core.
 * assumes a 32-bit classic wishbone slave with word-aligned registers.
 */
package hdu_pkg;

    // printed offsets step by one, not by four: they are register indices
    localparam logic [7:0]  IDX_DATA     = 8'hd6;
    localparam logic [7:0]  IDX_CONTROL  = 8'hd7;
    localparam logic [7:0]  IDX_STATUS   = 8'hd8;

    localparam logic [9:0]  ADDR_DATA    = {IDX_DATA, 2'b00};
    localparam logic [9:0]  ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [9:0]  ADDR_STATUS  = {IDX_STATUS, 2'b00};

    // serial_control field positions
    localparam int CTL_RX_READY  = 7;
    localparam int CTL_TX_EMPTY  = 6;
    localparam int CTL_RX_IEN    = 5;
    localparam int CTL_TX_IEN    = 4;
    localparam int CTL_BAUD_HI   = 3;
    localparam int CTL_BAUD_LO   = 1;
    localparam int CTL_PAR_NINTH = 0;

    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  DATA_RESET    = 8'h00;

    localparam int OVERSAMPLE = 8;
    // samples taken at these states of each bit (0..7)
    localparam logic [2:0]  SAMPLE_A = 3'h3;
    localparam logic [2:0]  SAMPLE_B = 3'h4;
    localparam logic [2:0]  SAMPLE_C = 3'h5;

    localparam logic [12:0] DIV_0 = 13'd6656;
    localparam logic [12:0] DIV_1 = 13'd3328;
    localparam logic [12:0] DIV_2 = 13'd1664;
    localparam logic [12:0] DIV_3 = 13'd832;
    localparam logic [12:0] DIV_4 = 13'd416;
    localparam logic [12:0] DIV_5 = 13'd256;
    localparam logic [12:0] DIV_6 = 13'd208;
    localparam logic [12:0] DIV_7 = 13'd104;

    typedef enum logic [1:0] {
        HDU_TX_IDLE,
        HDU_TX_START,
        HDU_TX_BITS,
        HDU_TX_STOP
    } hdu_tx_e;

    typedef enum logic [1:0] {
        HDU_RX_IDLE,
        HDU_RX_START,
        HDU_RX_BITS,
        HDU_RX_STOP
    } hdu_rx_e;

    // wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [9:0]  adr;
        logic [31:0] dat;
    } hdu_wb_req_s;

    // serial pin carrier
    typedef struct packed {
        logic out_level;
        logic out_select;
    } hdu_txpin_s;

endpackage

//--- verif/hdu_core_chk.sv
/* hdu_core_chk: bus and serial-pin assertions for hdu_core.
   sees only the core's ports; bound to every instance below. */
`timescale 1ns/1ps
module hdu_core_chk
    import hdu_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // serial side
    input wire logic        serial_out_pin,
    input wire logic        tx_output_select,
    input wire logic        tx_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic req;
    logic hit;
    logic dwr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit = wb_adr_i == ADDR_DATA || wb_adr_i == ADDR_CONTROL || wb_adr_i == ADDR_STATUS;
    // a completed write of the data byte
    assign dwr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_DATA;

    ack_latency_a: assert property (req && hit |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_unmapped_a: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    idle_high_a: assert property (!tx_output_select |-> serial_out_pin)
        else $error("pin low outside a frame");
    start_bit_a: assert property ($rose(tx_output_select) |-> !serial_out_pin)
        else $error("frame without start bit");
    stop_bit_a: assert property ($fell(tx_output_select) |-> $past(serial_out_pin))
        else $error("frame without stop bit");
    tx_go_a: assert property (dwr |-> ##[0:2] tx_output_select)
        else $error("data write did not start a frame");
    empty_clear_a: assert property (dwr |-> ##[1:2] !tx_irq)
        else $error("data write left empty flag set");
endmodule

bind hdu_core hdu_core_chk chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
    .wb_adr_i, .wb_ack_o, .wb_err_o, .serial_out_pin, .tx_output_select, .tx_irq);

//--- verif/hdu_peer.sv
/* hdu_peer: remote serial station facing the core's pins.
   assumes the bench gives the bit time in clk cycles and the frame option. */
`timescale 1ns/1ps
module hdu_peer
(
    // setup
    input  wire logic        clk,
    input  wire logic        nine,
    input  wire logic [15:0] bit_cyc,
    // link
    input  wire logic        line_in,
    output logic             line_out,
    // decoded frame: stop, ninth, byte
    output logic             got,
    output logic [9:0]       got_bits
);
    logic [9:0] v;
    int         nb;

    initial
    begin
        line_out = 1'b1;
        got = 1'b0;
        got_bits = 10'h0;
    end

    // mid-bit sampling absorbs the start bit's jitter of one divisor
    always
    begin
        @(negedge line_in);
        repeat (bit_cyc / 2) @(posedge clk);
        if (!line_in)
        begin
            v = 10'h0;
            nb = nine ? 9 : 8;
            for (int i = 0; i <= nb; i++)
            begin
                repeat (bit_cyc) @(posedge clk);
                if (i < nb)
                    v[i] = line_in;
                else
                    v[9] = line_in;
            end
            got_bits <= v;
            got <= 1'b1;
            @(posedge clk);
            got <= 1'b0;
        end
    end

    // line rests high between frames
    task automatic send(input logic [8:0] d);
        logic [10:0] f;
        f = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
        @(posedge clk);
        for (int i = 0; i < (nine ? 11 : 10); i++)
        begin
            line_out <= f[i];
            repeat (bit_cyc) @(posedge clk);
        end
    endtask
endmodule

//--- verif/tb.sv
/* tb: self-checking bench for hdu_core with a remote serial peer.
   assumes a 10 MHz clock and a port pin held high outside frames. */
`timescale 1ns/1ps
module tb;
    import hdu_pkg::*;
    logic        clk, arst_n, strap, sin, sout, tsel, rxi, txi, ack, err, e, got;
    logic [31:0] rdat;
    logic [15:0] bitc;
    logic [9:0]  gbits;
    logic [7:0]  r;
    logic [31:0] rd_q[$];
    logic [9:0]  fr_q[$];
    hdu_wb_req_s req;
    int          n_mismatch, check_count;
    wire         pin = tsel ? sout : 1'b1;

    hdu_core dut (.clk, .arst_n, .frame11_strap(strap), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .serial_in_pin(sin),
        .serial_out_pin(sout), .tx_output_select(tsel), .rx_irq(rxi), .tx_irq(txi));
    hdu_peer peer (.clk, .nine(strap), .bit_cyc(bitc), .line_in(pin), .line_out(sin),
        .got, .got_bits(gbits));

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // unused lanes and upper data bits carry random values the core must ignore
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic s);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, {3'($urandom), s}, a, {24'($urandom), d}};
        for (n = 0; !ack && !err && n < 50; n++)
            @(posedge clk);
        if (n == 50)
            chk(32'h0, 32'h1);
        e = err;
        req <= '0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] x);
        rd_q.push_back({24'h0, x});
        bus(1'b0, a, 8'h00, 1'b1);
    endtask

    task automatic irq(input logic tx, input logic x);
        repeat (2) @(posedge clk);
        chk({31'h0, tx ? txi : rxi}, {31'h0, x});
    endtask

    task automatic txwait();
        int n;
        repeat (4) @(posedge clk);
        for (n = 0; tsel && n < 40000; n++)
            @(posedge clk);
        if (n == 40000)
            chk(32'h0, 32'h1);
        repeat (4) @(posedge clk);
    endtask

    task automatic rst(input logic s);
        arst_n <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // read data and decoded frames are compared in order of issue
    always @(posedge clk)
    begin
        if (ack && !req.we)
            chk(rdat, rd_q.pop_front());
        if (got)
            chk({22'h0, gbits}, {22'h0, fr_q.pop_front()});
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // the run needs about 72000 cycles; the watchdog allows 90000
    initial
    begin
        #9000000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end

    initial
    begin
        req = '0;
        bitc = 16'd832;
        void'($urandom(32'h6bbf));
        r = 8'($urandom);
        rst(1'b0);
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(ADDR_DATA, DATA_RESET);
        rd(ADDR_STATUS, 8'h00);
        // lane 0 disabled: the write is acked but must not land
        bus(1'b1, ADDR_CONTROL, 8'hff, 1'b0);
        rd(ADDR_CONTROL, CONTROL_RESET);
        bus(1'b0, 10'h000, 8'h00, 1'b1);
        chk({31'h0, e}, 32'h1);
        $display("test registers done");
        // three ones in 0x07, so bit 7 leaves set
        wr(ADDR_CONTROL, 8'h0f);
        fr_q.push_back(10'h287);
        wr(ADDR_DATA, 8'h07);
        txwait();
        irq(1'b1, 1'b0);
        rd(ADDR_CONTROL, 8'h4f);
        wr(ADDR_CONTROL, 8'h1f);
        irq(1'b1, 1'b0);
        wr(ADDR_CONTROL, 8'h5f);
        irq(1'b1, 1'b1);
        bitc <= 16'd1664;
        wr(ADDR_CONTROL, 8'h5d);
        fr_q.push_back(10'h2a5);
        wr(ADDR_DATA, 8'h25);
        irq(1'b1, 1'b0);
        rd(ADDR_STATUS, 8'h04);
        txwait();
        irq(1'b1, 1'b1);
        $display("test transmit done");
        bitc <= 16'd832;
        wr(ADDR_CONTROL, 8'h2e);
        peer.send({1'b0, r});
        repeat (300) @(posedge clk);
        rd(ADDR_DATA, r);
        rd(ADDR_CONTROL, {7'h57, ^r});
        irq(1'b0, 1'b1);
        wr(ADDR_CONTROL, 8'h2e);
        irq(1'b0, 1'b0);
        wr(ADDR_CONTROL, 8'hae);
        irq(1'b0, 1'b1);
        $display("test receive done");
        // the control writes 0x2e and 0xae cleared the parity bit, so auto parity is switched on again
        wr(ADDR_CONTROL, 8'h0f);
        fr_q.push_back(10'h293);
        fork
            peer.send(9'h05a);
            begin
                repeat (1700) @(posedge clk);
                wr(ADDR_DATA, 8'h13);
            end
        join
        txwait();
        rd(ADDR_CONTROL, 8'h4f);
        rd(ADDR_DATA, r);
        $display("test abort done");
        rst(1'b1);
        wr(ADDR_CONTROL, 8'h0f);
        fr_q.push_back(10'h33c);
        wr(ADDR_DATA, 8'h3c);
        txwait();
        fr_q.push_back(10'h3c3);
        wr(ADDR_DATA, 8'hc3);
        txwait();
        peer.send(9'h066);
        repeat (300) @(posedge clk);
        rd(ADDR_DATA, 8'h66);
        rd(ADDR_CONTROL, 8'hce);
        rd(ADDR_STATUS, 8'h08);
        $display("test long frame done");
        results();
    end
endmodule
